/* core/pic_pkg.sv */
package pic_pkg;

    // ------------------------------------------------------------------
    // Widths and clocking
    // ------------------------------------------------------------------
    localparam int unsigned CNT_W         = 16;
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned BASE_HZ       = 10_000_000;
    localparam int unsigned PULSE_NS      = 500;
    localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    // Longest time rounds down, never below one cycle.
    localparam int unsigned PULSE_CYC_RAW = PULSE_NS / CLK_PERIOD_NS;
    localparam int unsigned PULSE_CYC     =
        (PULSE_CYC_RAW < 1) ? 1 : PULSE_CYC_RAW;
    localparam int unsigned PULSE_W       = 5;
    localparam logic [PULSE_W-1:0] PULSE_LEN = PULSE_W'(PULSE_CYC);

    // ------------------------------------------------------------------
    // Rate dividers: clock cycles per tick of each internal rate
    // ------------------------------------------------------------------
    localparam int unsigned BASE_DIV   = CLK_HZ / BASE_HZ;
    localparam int unsigned DIV_1M     = BASE_DIV * 10;
    localparam int unsigned DIV_100K   = BASE_DIV * 100;
    localparam int unsigned DIV_10K    = BASE_DIV * 1_000;
    localparam int unsigned DIV_1K     = BASE_DIV * 10_000;
    localparam int unsigned DIV_100    = BASE_DIV * 100_000;
    localparam int unsigned DIV_W      = 18;

    // ------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------
    localparam logic [CNT_W-1:0] CNT_RST   = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_MAX   = 16'hFFFF;

    typedef enum logic [1:0] {
        PIC_SINGLE,
        PIC_REPEAT,
        PIC_EVT_TIME,
        PIC_EVT_ZERO
    } pic_mode_e;

    typedef enum logic [2:0] {
        PIC_SRC_STOP,
        PIC_SRC_1M,
        PIC_SRC_100K,
        PIC_SRC_10K,
        PIC_SRC_1K,
        PIC_SRC_100,
        PIC_SRC_LINE,
        PIC_SRC_EV1
    } pic_src_e;

endpackage

/* core/pic_edge_pulse.sv */
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// Input synchroniser, edge selection and active-low echo pulse
// ----------------------------------------------------------------------
module pic_edge_pulse
    import pic_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    input  wire logic sig_i,
    input  wire logic falling_i,
    input  wire logic pulse_i,
    output logic      edge_o,
    output logic      pulse_n_o
);

    logic               sync1_ff;
    logic               sync2_ff;
    logic               prev_ff;
    logic [PULSE_W-1:0] cnt_ff;
    logic               pulse_n_ff;
    logic [PULSE_W-1:0] nxt_cnt;
    logic               nxt_pulse_n;
    logic [1:0]         warm_ff;
    logic [1:0]         nxt_warm;
    logic               armed;

    // The first stage feeds only the second stage. Edges are ignored
    // until the history holds a real pin sample, so a pin that idles
    // high gives no false rising edge after reset.
    assign armed  = (warm_ff == 2'h3);
    assign edge_o = armed & (falling_i ? (prev_ff & ~sync2_ff)
                                       : (~prev_ff & sync2_ff));
    assign pulse_n_o = pulse_n_ff;

    always_comb
    begin
        nxt_warm    = armed ? warm_ff : warm_ff + 2'h1;
        nxt_cnt     = cnt_ff;
        nxt_pulse_n = pulse_n_ff;
        if (pulse_i)
        begin
            nxt_cnt     = PULSE_LEN;
            nxt_pulse_n = 1'b0;
        end
        else if (cnt_ff > PULSE_W'(1))
        begin
            nxt_cnt = cnt_ff - PULSE_W'(1);
        end
        else
        begin
            nxt_cnt     = '0;
            nxt_pulse_n = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sync1_ff   <= 1'b0;
            sync2_ff   <= 1'b0;
            prev_ff    <= 1'b0;
            warm_ff    <= 2'h0;
            cnt_ff     <= '0;
            pulse_n_ff <= 1'b1;
        end
        else
        begin
            sync1_ff   <= sig_i;
            sync2_ff   <= sync1_ff;
            prev_ff    <= sync2_ff;
            warm_ff    <= nxt_warm;
            cnt_ff     <= nxt_cnt;
            pulse_n_ff <= nxt_pulse_n;
        end
    end

endmodule

/* core/pic_counter.sv */
`timescale 1ns/100ps

// Behaviour
// (R1) The interval and event counter is a 16-bit binary counter.
// (R2) Five rates of 1 MHz to 100 Hz are divided down from a 10 MHz base.
// (R3) The line-frequency event signal may be chosen as the count source.
// (R4) Four modes exist: single, repeated, event timing, zero-base timing.
// (R5) Each overflow gives an active-low pulse of about 500 ns.
// (R6) A trigger-two event starts counting, sets its flag and may interrupt.
// (R7) A trigger-two event copies the counter into the buffer/preset reg; here only in event and zero-base timing modes.
// (R8) Trigger one can clock the counter as a time base or event source.
// (R9) Each trigger fires on a rising or falling edge chosen by a switch.
// (R10) Trigger events are echoed on active-low outputs like the overflow.
// (R11) Trigger events can start counting, a conversion or an interrupt.
// (R12) Single mode stops after overflow; repeated mode keeps counting.
// (R13) Software preloads the two's complement of the wanted count.
// (R14) Zero-base mode clears the counter right after the capture.
// (R15) A second overflow or trigger-two event before service sets overrun.
// (R16) Inputs are synchronised and each qualifying edge counts once.
module pic_counter
    import pic_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             arst_n_i,
    input  wire logic [1:0]       mode_i,
    input  wire logic [2:0]       rate_sel_i,
    input  wire logic             go_set_i,
    input  wire logic             go_clr_i,
    input  wire logic             ev2_go_en_i,
    input  wire logic             irq_en_i,
    input  wire logic             preset_we_i,
    input  wire logic [CNT_W-1:0] preset_i,
    input  wire logic             ovf_clr_i,
    input  wire logic             ev2_clr_i,
    input  wire logic             ovr_clr_i,
    input  wire logic             line_evt_i,
    input  wire logic             event_input_one_i,
    input  wire logic             event_input_two_i,
    input  wire logic             ev1_falling_i,
    input  wire logic             ev2_falling_i,
    output logic [CNT_W-1:0]      buffer_preset_reg_o,
    output logic                  go_o,
    output logic                  ovf_flag_o,
    output logic                  event_two_flag_o,
    output logic                  overrun_flag_o,
    output logic                  irq_o,
    output logic                  overflow_pulse_n_o,
    output logic                  event_one_echo_n_o,
    output logic                  event_two_echo_n_o
);

    // ------------------------------------------------------------------
    // Inputs: synchronise, pick edge, echo
    // ------------------------------------------------------------------
    logic ev1_edge;
    logic ev2_edge;
    logic line_edge;
    logic ovf_pulse;

    pic_edge_pulse u_ev1 (                          // [R8] [R9] [R16]
        .clk_i     (clk_i),
        .arst_n_i  (arst_n_i),
        .sig_i     (event_input_one_i),
        .falling_i (ev1_falling_i),
        .pulse_i   (ev1_edge),
        .edge_o    (ev1_edge),
        .pulse_n_o (event_one_echo_n_o)             // [R10]
    );

    pic_edge_pulse u_ev2 (                          // [R9] [R16]
        .clk_i     (clk_i),
        .arst_n_i  (arst_n_i),
        .sig_i     (event_input_two_i),
        .falling_i (ev2_falling_i),
        .pulse_i   (ev2_edge),
        .edge_o    (ev2_edge),
        .pulse_n_o (event_two_echo_n_o)             // [R10] [R11]
    );

    // The line signal is counted on its rising edge; nothing echoes it.
    pic_edge_pulse u_line (                         // [R3] [R16]
        .clk_i     (clk_i),
        .arst_n_i  (arst_n_i),
        .sig_i     (line_evt_i),
        .falling_i (1'b0),
        .pulse_i   (1'b0),
        .edge_o    (line_edge),
        .pulse_n_o ()
    );

    // Overflow uses the same stretcher; its input path is unused.
    pic_edge_pulse u_ovf (                          // [R5] [R11]
        .clk_i     (clk_i),
        .arst_n_i  (arst_n_i),
        .sig_i     (1'b0),
        .falling_i (1'b0),
        .pulse_i   (ovf_pulse),
        .edge_o    (),
        .pulse_n_o (overflow_pulse_n_o)
    );

    // ------------------------------------------------------------------
    // Rate divider chain
    // ------------------------------------------------------------------
    logic [DIV_W-1:0] div_ff;
    logic [DIV_W-1:0] nxt_div;
    logic [DIV_W-1:0] div_end;
    logic             rate_tick;

    // One counter reloads at the selected rate; a new selection takes
    // effect within one period of the new rate, a cheap trade-off.
    always_comb
    begin
        unique case (pic_src_e'(rate_sel_i))                    // [R2]
            PIC_SRC_1M:   div_end = DIV_W'(DIV_1M - 1);
            PIC_SRC_100K: div_end = DIV_W'(DIV_100K - 1);
            PIC_SRC_10K:  div_end = DIV_W'(DIV_10K - 1);
            PIC_SRC_1K:   div_end = DIV_W'(DIV_1K - 1);
            PIC_SRC_100:  div_end = DIV_W'(DIV_100 - 1);
            default:      div_end = '0;
        endcase
        rate_tick = (div_ff >= div_end);
        nxt_div   = rate_tick ? '0 : div_ff + DIV_W'(1);
    end

    // ------------------------------------------------------------------
    // Counter, modes and flags
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] bufreg_ff;
    logic             go_ff;
    logic             ovf_ff;
    logic             ev2f_ff;
    logic             ovr_ff;
    logic             irq_ff;
    logic             pls_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic [CNT_W-1:0] nxt_bufreg;
    logic             nxt_go;
    logic             nxt_ovf;
    logic             nxt_ev2f;
    logic             nxt_ovr;
    logic             nxt_irq;
    logic             tick;
    logic             wrap;
    logic             ev2_go;
    logic             interval;

    assign ovf_pulse = pls_ff;

    always_comb
    begin
        interval = (pic_mode_e'(mode_i) == PIC_SINGLE)
                || (pic_mode_e'(mode_i) == PIC_REPEAT);              // [R4]
        unique case (pic_src_e'(rate_sel_i))
            PIC_SRC_STOP: tick = 1'b0;
            PIC_SRC_LINE: tick = line_edge;                          // [R3]
            PIC_SRC_EV1:  tick = ev1_edge;                           // [R8]
            default:      tick = rate_tick;                          // [R2]
        endcase
        ev2_go   = ev2_edge & ev2_go_en_i;                           // [R6]
        wrap     = go_ff & tick & (cnt_ff == CNT_MAX);               // [R1]
        nxt_cnt  = cnt_ff;
        nxt_bufreg = bufreg_ff;
        nxt_go   = go_ff;
        nxt_ovf  = ovf_ff & ~ovf_clr_i;
        nxt_ev2f = ev2f_ff & ~ev2_clr_i;
        nxt_ovr  = ovr_ff & ~ovr_clr_i;

        if (go_ff && tick)
        begin
            nxt_cnt = cnt_ff + CNT_W'(1);                            // [R1]
        end
        if (preset_we_i)
        begin
            nxt_bufreg = preset_i;                                   // [R13]
        end
        if (wrap)
        begin
            nxt_ovf = 1'b1;
            if (ovf_ff)
            begin
                nxt_ovr = 1'b1;                                      // [R15]
            end
            if (interval)
            begin
                nxt_cnt = bufreg_ff;                                 // [R12]
                if (pic_mode_e'(mode_i) == PIC_SINGLE)
                begin
                    nxt_go = 1'b0;                                   // [R12]
                end
            end
        end
        if (go_clr_i)
        begin
            nxt_go = 1'b0;
        end
        // Start after a stop, so that a trigger in the clear cycle wins.
        if (go_set_i || ev2_go)
        begin
            nxt_go = 1'b1;                                           // [R6]
            if (!go_ff && interval)
            begin
                nxt_cnt = bufreg_ff;
            end
        end
        if (ev2_edge)
        begin
            nxt_ev2f = 1'b1;                                         // [R6]
            if (ev2f_ff)
            begin
                nxt_ovr = 1'b1;                                      // [R15]
            end
            if (!interval)
            begin
                nxt_bufreg = cnt_ff;                                 // [R7]
                if (pic_mode_e'(mode_i) == PIC_EVT_ZERO)
                begin
                    nxt_cnt = CNT_RST;                               // [R14]
                end
            end
        end
        nxt_irq = irq_en_i & (nxt_ovf | nxt_ev2f);                   // [R6]
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            div_ff  <= '0;
            cnt_ff  <= CNT_RST;
            bufreg_ff <= CNT_RST;
            go_ff   <= 1'b0;
            ovf_ff  <= 1'b0;
            ev2f_ff <= 1'b0;
            ovr_ff  <= 1'b0;
            irq_ff  <= 1'b0;
            pls_ff  <= 1'b0;
        end
        else
        begin
            div_ff  <= nxt_div;
            cnt_ff  <= nxt_cnt;
            bufreg_ff <= nxt_bufreg;
            go_ff   <= nxt_go;
            ovf_ff  <= nxt_ovf;
            ev2f_ff <= nxt_ev2f;
            ovr_ff  <= nxt_ovr;
            irq_ff  <= nxt_irq;
            pls_ff  <= wrap;                                         // [R5]
        end
    end

    assign buffer_preset_reg_o = bufreg_ff;
    assign go_o                = go_ff;
    assign ovf_flag_o          = ovf_ff;
    assign event_two_flag_o    = ev2f_ff;
    assign overrun_flag_o      = ovr_ff;
    assign irq_o               = irq_ff;

endmodule

/* tb/pic_counter_checker.sv */
`timescale 1ns/100ps

module pic_counter_checker (
    input wire logic        clk_i,
    input wire logic        arst_n_i,
    input wire logic [1:0]  mode_i,
    input wire logic        go_set_i,
    input wire logic        go_clr_i,
    input wire logic        ev2_go_en_i,
    input wire logic        preset_we_i,
    input wire logic [15:0] buffer_preset_reg_o,
    input wire logic        go_o,
    input wire logic        ovf_flag_o,
    input wire logic        event_two_flag_o,
    input wire logic        overrun_flag_o,
    input wire logic        overflow_pulse_n_o,
    input wire logic        event_one_echo_n_o,
    input wire logic        event_two_echo_n_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    // ----------------------------------------------------------------
    // Pulse outputs
    // ----------------------------------------------------------------
    ovf_pulse_a: assert property (
        $rose(ovf_flag_o) |=> !overflow_pulse_n_o)
        else $error("overflow pulse missing");
    pulse_len_a: assert property (
        $fell(overflow_pulse_n_o) |=>
        (!overflow_pulse_n_o)[*8] ##1 !overflow_pulse_n_o)
        else $error("overflow pulse too short");
    echo_len_a: assert property (
        $fell(event_one_echo_n_o) |=>
        (!event_one_echo_n_o)[*8] ##1 !event_one_echo_n_o)
        else $error("echo pulse too short");
    echo_two_a: assert property (
        $rose(event_two_flag_o) |-> ##[0:2] !event_two_echo_n_o)
        else $error("second echo missing");

    // ----------------------------------------------------------------
    // Modes, flags and register
    // ----------------------------------------------------------------
    stop_mode_a: assert property (
        $rose(ovf_flag_o) && mode_i == 2'h0 && $past(mode_i) == 2'h0 &&
        !$past(go_set_i) && !$past(ev2_go_en_i) |-> !go_o)
        else $error("single mode kept running");
    repeat_mode_a: assert property (
        $rose(ovf_flag_o) && mode_i == 2'h1 && $past(mode_i) == 2'h1 &&
        !$past(go_clr_i) |-> go_o)
        else $error("repeat mode stopped");
    overrun_cause_a: assert property (
        $rose(overrun_flag_o) |-> ovf_flag_o || event_two_flag_o)
        else $error("overrun without pending flag");
    preset_hold_a: assert property (
        $changed(buffer_preset_reg_o) |->
        $past(preset_we_i) || $past(mode_i[1]))
        else $error("register changed without cause");

    cover property ($rose(ovf_flag_o) && mode_i == 2'h1);
    cover property ($rose(overrun_flag_o));
    cover property ($rose(event_two_flag_o) && mode_i == 2'h3);
endmodule

bind pic_counter pic_counter_checker chk_u (
    .clk_i               (clk_i),
    .arst_n_i            (arst_n_i),
    .mode_i              (mode_i),
    .go_set_i            (go_set_i),
    .go_clr_i            (go_clr_i),
    .ev2_go_en_i         (ev2_go_en_i),
    .preset_we_i         (preset_we_i),
    .buffer_preset_reg_o (buffer_preset_reg_o),
    .go_o                (go_o),
    .ovf_flag_o          (ovf_flag_o),
    .event_two_flag_o    (event_two_flag_o),
    .overrun_flag_o      (overrun_flag_o),
    .overflow_pulse_n_o  (overflow_pulse_n_o),
    .event_one_echo_n_o  (event_one_echo_n_o),
    .event_two_echo_n_o  (event_two_echo_n_o)
);

/* tb/pic_evt_src.sv */
`timescale 1ns/100ps

// ----------------------------------------------------------------
// External signal source for a trigger or line input
// ----------------------------------------------------------------
module pic_evt_src (
    input  wire logic clk_i,
    input  wire logic fire_i,
    input  wire logic falling_i,
    output logic      sig_o
);
    logic [2:0] hold_ff = 3'h0;

    // The active level stands four cycles, longer than the device's
    // synchroniser and edge detector need, so no event is missed.
    always_ff @(posedge clk_i)
        hold_ff <= fire_i ? 3'h4 : (hold_ff == 3'h0 ? 3'h0 : hold_ff - 3'h1);

    assign sig_o = falling_i ^ (hold_ff != 3'h0);
endmodule

/* tb/tb_programmable_interval_counter.sv */
`timescale 1ns/100ps

module tb_programmable_interval_counter;
    import pic_pkg::*;

    logic             clk_i = 1'b0;
    logic             arst_n_i = 1'b0;
    logic [1:0]       mode_i = 2'h0;
    logic [2:0]       rate_sel_i = 3'h0;
    logic             ev2_go_en_i = 1'b0;
    logic             irq_en_i = 1'b0;
    logic             ev1_falling_i = 1'b1;
    logic             ev2_falling_i = 1'b0;
    logic [CNT_W-1:0] preset_i = 16'h0000;
    logic [5:0]       ctl = 6'h00;
    logic [2:0]       fire = 3'h0;
    logic go_set_i, go_clr_i, preset_we_i, ovf_clr_i, ev2_clr_i, ovr_clr_i;
    logic line_evt_i, event_input_one_i, event_input_two_i;
    logic [CNT_W-1:0] buffer_preset_reg_o;
    logic go_o, ovf_flag_o, event_two_flag_o, overrun_flag_o, irq_o;
    logic overflow_pulse_n_o, event_one_echo_n_o, event_two_echo_n_o;
    int               fail_count = 0;
    int               checks_done = 0;
    int               n;
    int               divs [4] = '{DIV_1M, DIV_100K, DIV_10K, DIV_1K};

    assign {ovr_clr_i, ev2_clr_i, ovf_clr_i, preset_we_i, go_clr_i,
            go_set_i} = ctl;

    pic_counter uut (
        .clk_i               (clk_i),
        .arst_n_i            (arst_n_i),
        .mode_i              (mode_i),
        .rate_sel_i          (rate_sel_i),
        .go_set_i            (go_set_i),
        .go_clr_i            (go_clr_i),
        .ev2_go_en_i         (ev2_go_en_i),
        .irq_en_i            (irq_en_i),
        .preset_we_i         (preset_we_i),
        .preset_i            (preset_i),
        .ovf_clr_i           (ovf_clr_i),
        .ev2_clr_i           (ev2_clr_i),
        .ovr_clr_i           (ovr_clr_i),
        .line_evt_i          (line_evt_i),
        .event_input_one_i   (event_input_one_i),
        .event_input_two_i   (event_input_two_i),
        .ev1_falling_i       (ev1_falling_i),
        .ev2_falling_i       (ev2_falling_i),
        .buffer_preset_reg_o (buffer_preset_reg_o),
        .go_o                (go_o),
        .ovf_flag_o          (ovf_flag_o),
        .event_two_flag_o    (event_two_flag_o),
        .overrun_flag_o      (overrun_flag_o),
        .irq_o               (irq_o),
        .overflow_pulse_n_o  (overflow_pulse_n_o),
        .event_one_echo_n_o  (event_one_echo_n_o),
        .event_two_echo_n_o  (event_two_echo_n_o)
    );
    pic_evt_src line_src (.clk_i(clk_i), .fire_i(fire[0]),
        .falling_i(1'b0), .sig_o(line_evt_i));
    pic_evt_src one_src (.clk_i(clk_i), .fire_i(fire[1]),
        .falling_i(ev1_falling_i), .sig_o(event_input_one_i));
    pic_evt_src two_src (.clk_i(clk_i), .fire_i(fire[2]),
        .falling_i(ev2_falling_i), .sig_o(event_input_two_i));

    always #25 clk_i = ~clk_i;

    // ----------------------------------------------------------------
    // Access tasks
    // ----------------------------------------------------------------
    task automatic cyc(input int k);
        repeat (k) @(negedge clk_i);
    endtask

    task automatic chk(input logic [CNT_W-1:0] got,
                       input logic [CNT_W-1:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t ns: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    // Control strobes stand one cycle; the idle cycle after keeps two
    // strobes from merging into one.
    task automatic strobe(input int k);
        ctl = 6'h01 << k;
        cyc(1);
        ctl = 6'h00;
        cyc(1);
    endtask

    task automatic pulse_src(input int k, input int times);
        repeat (times)
        begin
            fire = 3'h1 << k;
            cyc(1);
            fire = 3'h0;
            cyc(12);
        end
    endtask

    task automatic wait_ovf(input int lim);
        n = 0;
        while (!ovf_flag_o && n < lim)
        begin
            cyc(1);
            n++;
        end
        chk(ovf_flag_o, 1'b1);
        if (ovf_flag_o !== 1'b1)
            give_verdict();
    endtask

    task automatic give_verdict();
        $display("checks %0d, errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial
    begin
        cyc(8);
        arst_n_i = 1'b1;
        cyc(1);
        chk(buffer_preset_reg_o, CNT_RST);
        chk({go_o, ovf_flag_o}, 2'h0);
        chk({event_two_flag_o, overrun_flag_o}, 2'h0);
        chk(overflow_pulse_n_o, 1'b1);
        chk({event_one_echo_n_o, event_two_echo_n_o}, 2'h3);
        preset_i = 16'hFFFE;
        strobe(2);
        chk(buffer_preset_reg_o, 16'hFFFE);
        for (int r = 0; r < 4; r++)
        begin
            rate_sel_i = 3'(r + 1);
            strobe(0);
            wait_ovf(3 * divs[r]);
            chk(n + 3 >= divs[r], 1'b1);
            chk(n <= 2 * divs[r] + divs[r] / 4, 1'b1);
            chk(go_o, 1'b0);
            cyc(1);
            chk(overflow_pulse_n_o, 1'b0);
            cyc(10);
            chk(overflow_pulse_n_o, 1'b1);
            strobe(3);
            chk(ovf_flag_o, 1'b0);
        end
        mode_i = 2'h1;
        rate_sel_i = 3'h1;
        irq_en_i = 1'b1;
        preset_i = 16'hFFFF;
        strobe(2);
        strobe(0);
        wait_ovf(60);
        chk(go_o, 1'b1);
        cyc(1);
        chk(irq_o, 1'b1);
        cyc(30);
        chk(overrun_flag_o, 1'b1);
        strobe(1);
        strobe(3);
        strobe(5);
        chk({go_o, ovf_flag_o, overrun_flag_o, irq_o}, 4'h0);
        mode_i = 2'h3;
        rate_sel_i = 3'h7;
        ev2_go_en_i = 1'b1;
        pulse_src(2, 1);
        chk({go_o, event_two_flag_o, irq_o}, 3'h7);
        strobe(4);
        pulse_src(1, 2);
        pulse_src(2, 1);
        chk(buffer_preset_reg_o, 16'h0002);
        strobe(4);
        pulse_src(1, 1);
        pulse_src(2, 1);
        chk(buffer_preset_reg_o, 16'h0001);
        mode_i = 2'h2;
        rate_sel_i = 3'h6;
        pulse_src(0, 3);
        pulse_src(2, 1);
        chk(buffer_preset_reg_o, 16'h0003);
        pulse_src(0, 1);
        pulse_src(2, 1);
        chk(buffer_preset_reg_o, 16'h0004);
        chk(overrun_flag_o, 1'b1);
        // Trigger two now fires on the falling edge of its pin.
        ev2_falling_i = 1'b1;
        cyc(4);
        pulse_src(0, 2);
        pulse_src(2, 1);
        chk(buffer_preset_reg_o, 16'h0006);
        // A stopped rate source must leave the counter where it is.
        rate_sel_i = 3'h0;
        cyc(40);
        pulse_src(2, 1);
        chk(buffer_preset_reg_o, 16'h0006);
        give_verdict();
    end
endmodule
